// file: verilog/fiw_regs.sv
// Summary of operation
// - Threshold bits 2:0 pick loop kick-in 2.4V down to 1.7V, 0.1V steps.
// - Threshold bits 5:3 pick limit kick-in 2.7V down to 2.0V, 0.1V steps.
// - Guard bit 7 set blocks writes to all but the guard; resets to 0.
// - Every register but clear-all (which reads zero) reads back regardless of the guard setting.
// - Any latched fault pulls the active-low alert output low.
// - Fault flags stay latched until clear-all or a matching write-back.
// - Index bit n is set while status register 0xD2+n holds a fault.
// - Index bit 7 is set while the alert is held low.
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "fiw_map.svh"

module fiw_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire fiw_pkg::fiw_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output fiw_pkg::fiw_byte_t reg_rdata,
    // Fault detectors
    input wire logic [55:0] fault_det_in,
    // Alert pin
    output logic fault_alert_n,
    // Kick-in thresholds for the current loops
    output fiw_pkg::fiw_mv_t constant_current_loop_mv,
    output fiw_pkg::fiw_mv_t average_current_limit_mv
);
    import fiw_pkg::*;

    fiw_fault_if fault_bus ();

    fiw_byte_t guard_q;
    fiw_byte_t thresh_q;
    fiw_byte_t rdata_q;
    logic alert_n_q;
    fiw_mv_t ccl_mv_q;
    fiw_mv_t acl_mv_q;
    logic wr_ok;
    logic [6:0] fault_any;
    fiw_byte_t index_w;
    fiw_byte_t rd_mux;
    logic [2:0] fault_sel;
    logic in_fault_range;

    // ************************************************************
    // Fault flag storage
    // ************************************************************
    fiw_fault_bank u_bank (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .fault_det_in(fault_det_in),
        .bus(fault_bus.bank)
    );

    // ************************************************************
    // Write guard
    // ************************************************************
    // The guard register itself stays writable so software can reopen
    assign wr_ok = reg_wr && (!guard_q[`FIW_GUARD_BIT] ||
                   reg_addr == `FIW_ADDR_WRITE_GUARD);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            guard_q <= `FIW_RST_GUARD;
        end else if (clk_en && reg_wr && reg_addr == `FIW_ADDR_WRITE_GUARD) begin
            guard_q <= {reg_wdata[`FIW_GUARD_BIT], 7'h00};
        end
    end

    // ************************************************************
    // Clear strobes toward the flag bank
    // ************************************************************
    // Clearing relies on the host having opened the guard first
    assign fault_bus.clear_all = clk_en && wr_ok &&
                                 reg_addr == `FIW_ADDR_CLEAR_ALL;
    assign fault_bus.wdata = reg_wdata;

    assign in_fault_range = reg_addr >= `FIW_ADDR_FAULT_FIRST &&
                            reg_addr <= `FIW_ADDR_FAULT_LAST;
    assign fault_sel = 3'(reg_addr - `FIW_ADDR_FAULT_FIRST);

    for (genvar g = 0; g < `FIW_FAULT_REGS; g++) begin : g_fault
        assign fault_bus.wr_sel[g] = clk_en && wr_ok && in_fault_range &&
                                     fault_sel == 3'(g);
        assign fault_any[g] = |fault_bus.flags[g];
    end

    // ************************************************************
    // Fault index and alert
    // ************************************************************
    assign index_w = {~alert_n_q, fault_any};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_n_q <= 1'b1;
        end else if (clk_en) begin
            alert_n_q <= ~(|fault_any);
        end
    end

    // ************************************************************
    // Thresholds
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            thresh_q <= `FIW_RST_THRESH;
        end else if (clk_en && wr_ok && reg_addr == `FIW_ADDR_THRESHOLDS) begin
            thresh_q <= reg_wdata & `FIW_THR_MASK;
        end
    end

    // Registered so the analog side sees a glitch-free code
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ccl_mv_q <= `FIW_CCL_BASE_MV;
            acl_mv_q <= `FIW_ACL_BASE_MV;
        end else if (clk_en) begin
            ccl_mv_q <= `FIW_CCL_BASE_MV - `FIW_STEP_MV *
                        {9'h000, thresh_q[`FIW_CCL_LSB +: 3]};
            acl_mv_q <= `FIW_ACL_BASE_MV - `FIW_STEP_MV *
                        {9'h000, thresh_q[`FIW_ACL_LSB +: 3]};
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    // Reads never look at the guard; unmapped offsets read zero
    always_comb begin
        rd_mux = 8'h00;
        if (in_fault_range) begin
            rd_mux = fault_bus.flags[fault_sel];
        end else begin
            unique case (reg_addr)
                `FIW_ADDR_WRITE_GUARD: rd_mux = guard_q;
                `FIW_ADDR_FAULT_INDEX: rd_mux = index_w;
                `FIW_ADDR_THRESHOLDS: rd_mux = thresh_q;
                default: rd_mux = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (clk_en) begin
            rdata_q <= reg_rd ? rd_mux : 8'h00;
        end
    end

    assign reg_rdata = rdata_q;
    assign fault_alert_n = alert_n_q;
    assign constant_current_loop_mv = ccl_mv_q;
    assign average_current_limit_mv = acl_mv_q;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    guard_write_a: assert property (clk_en && reg_wr &&
        reg_addr == `FIW_ADDR_WRITE_GUARD
        |=> guard_q == {$past(reg_wdata[7]), 7'h00})
        else $error("guard write not taken");
    blocked_write_a: assert property (clk_en && reg_wr && guard_q[7] &&
        reg_addr == `FIW_ADDR_THRESHOLDS |=> $stable(thresh_q))
        else $error("guarded threshold write took effect");
    open_write_a: assert property (clk_en && reg_wr && !guard_q[7] &&
        reg_addr == `FIW_ADDR_THRESHOLDS
        |=> thresh_q == ($past(reg_wdata) & 8'h3F))
        else $error("open threshold write lost");
    ccl_decode_a: assert property (clk_en
        |=> ccl_mv_q == 12'h960 - 12'h064 * {9'h000, $past(thresh_q[2:0])})
        else $error("loop kick-in decode wrong");
    acl_decode_a: assert property (clk_en
        |=> acl_mv_q == 12'hA8C - 12'h064 * {9'h000, $past(thresh_q[5:3])})
        else $error("limit kick-in decode wrong");
    read_back_a: assert property (clk_en && reg_rd && guard_q[7] &&
        reg_addr == `FIW_ADDR_THRESHOLDS
        |=> reg_rdata == $past(thresh_q) ##1 !clk_en || reg_rdata == 8'h00
        || $past(reg_rd))
        else $error("read while guarded failed");
    alert_follow_a: assert property (clk_en
        |=> fault_alert_n == !$past(|fault_bus.flags))
        else $error("alert does not follow flags");
    index_read_a: assert property (clk_en && reg_rd &&
        reg_addr == `FIW_ADDR_FAULT_INDEX
        |=> reg_rdata[0] == $past(|fault_bus.flags[0]) &&
            reg_rdata[6] == $past(|fault_bus.flags[6]) &&
            reg_rdata[7] == $past(!alert_n_q))
        else $error("fault index read wrong");

    // A closed guard must keep every clear away from the flag bank
    guard_clear_a: assert property (guard_q[7] &&
        reg_addr != `FIW_ADDR_WRITE_GUARD
        |-> !fault_bus.clear_all && fault_bus.wr_sel == 7'h00)
        else $error("clear passed a closed guard");
    index_mid_a: assert property (clk_en && reg_rd &&
        reg_addr == `FIW_ADDR_FAULT_INDEX
        |=> reg_rdata[5:1] == {$past(|fault_bus.flags[5]),
            $past(|fault_bus.flags[4]), $past(|fault_bus.flags[3]),
            $past(|fault_bus.flags[2]), $past(|fault_bus.flags[1])})
        else $error("middle fault index bits wrong");
    read_idle_a: assert property (clk_en && !reg_rd
        |=> reg_rdata == 8'h00)
        else $error("read data outside a read cycle");
    status_read_a: assert property (clk_en && reg_rd &&
        in_fault_range |=> reg_rdata == $past(fault_bus.flags[fault_sel]))
        else $error("status register read wrong");
    guard_rsvd_a: assert property (guard_q[6:0] == 7'h00)
        else $error("guard reserved bits set");
    freeze_a: assert property (!clk_en
        |=> $stable(thresh_q) && $stable(guard_q) &&
            $stable(reg_rdata) && $stable(fault_alert_n))
        else $error("state moved with the enable low");
endmodule : fiw_regs

`default_nettype wire

// file: include/fiw_map.svh
`ifndef FIW_MAP_SVH
`define FIW_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define FIW_ADDR_WRITE_GUARD 8'h10
`define FIW_ADDR_FAULT_INDEX 8'hC0
`define FIW_ADDR_THRESHOLDS 8'hED
`define FIW_ADDR_FAULT_FIRST 8'hD2
`define FIW_ADDR_FAULT_LAST 8'hD8
`define FIW_ADDR_CLEAR_ALL 8'h03

// ****************************************************************
// Field positions and masks
// ****************************************************************
`define FIW_GUARD_BIT 7
`define FIW_ALERT_BIT 7
`define FIW_CCL_LSB 0
`define FIW_ACL_LSB 3
`define FIW_THR_MASK 8'h3F
`define FIW_FAULT_REGS 7

// ****************************************************************
// Reset values
// ****************************************************************
`define FIW_RST_GUARD 8'h00
`define FIW_RST_THRESH 8'h00
`define FIW_RST_FAULT 8'h00

// ****************************************************************
// Kick-in voltages in millivolts: code 0 value, drop per code
// ****************************************************************
`define FIW_CCL_BASE_MV 12'h960
`define FIW_ACL_BASE_MV 12'hA8C
`define FIW_STEP_MV 12'h064

`endif

// file: include/fiw_pkg.sv
package fiw_pkg;
    typedef logic [7:0] fiw_byte_t;
    typedef logic [11:0] fiw_mv_t;
    typedef logic [6:0][7:0] fiw_fault_regs_t;
endpackage : fiw_pkg

// file: include/fiw_fault_if.sv
`timescale 1ns/10ps
`default_nettype none

interface fiw_fault_if;
    logic [6:0] wr_sel;
    fiw_pkg::fiw_byte_t wdata;
    logic clear_all;
    fiw_pkg::fiw_fault_regs_t flags;

    modport bank (
        input wr_sel,
        input wdata,
        input clear_all,
        output flags
    );
    modport ctrl (
        output wr_sel,
        output wdata,
        output clear_all,
        input flags
    );
endinterface : fiw_fault_if

`default_nettype wire

// file: verilog/fiw_fault_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "fiw_map.svh"

module fiw_fault_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Raw fault detector levels, eight per status register
    input wire logic [55:0] fault_det_in,
    // Register side
    fiw_fault_if.bank bus
);
    import fiw_pkg::*;

    logic [55:0] det_meta_q;
    logic [55:0] det_sync_q;
    fiw_fault_regs_t flags_q;

    // ************************************************************
    // Detector synchroniser
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            det_meta_q <= '0;
            det_sync_q <= '0;
        end else if (clk_en) begin
            det_meta_q <= fault_det_in;
            det_sync_q <= det_meta_q;
        end
    end

    // ************************************************************
    // Latched flags
    // ************************************************************
    // A detection in the clearing cycle is ORed in last, so it wins
    for (genvar g = 0; g < `FIW_FAULT_REGS; g++) begin : g_flag
        fiw_byte_t clr;
        assign clr = bus.clear_all ? 8'hFF :
                     (bus.wr_sel[g] ? (bus.wdata & flags_q[g]) : 8'h00);
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                flags_q[g] <= `FIW_RST_FAULT;
            end else if (clk_en) begin
                flags_q[g] <= (flags_q[g] & ~clr) | det_sync_q[g*8 +: 8];
            end
        end
    end

    assign bus.flags = flags_q;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    latch_hold_a: assert property (clk_en && !bus.clear_all && !bus.wr_sel[0]
        |=> (flags_q[0] & $past(flags_q[0])) == $past(flags_q[0]))
        else $error("fault flag lost without a clear");
    clear_all_a: assert property (clk_en && bus.clear_all && !(|det_sync_q)
        |=> flags_q == '0)
        else $error("clear-all left a flag set");
    set_wins_a: assert property (clk_en
        |=> (flags_q[1] & $past(det_sync_q[15:8])) == $past(det_sync_q[15:8]))
        else $error("detection lost in clearing cycle");
endmodule : fiw_fault_bank

`default_nettype wire

// file: tb/fiw_host.sv
`timescale 1ns/10ps
`default_nettype none

module fiw_host (
    // Clock
    input wire logic clk,
    // Register port
    output logic [7:0] reg_addr,
    output fiw_pkg::fiw_byte_t reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    import fiw_pkg::*;

    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Write data is inverted once taken, so a stale byte is never reused
    task automatic wr(input logic [7:0] a, input fiw_byte_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : rd

    // Guard is opened before any clearing write
    task automatic clr(input logic [7:0] a, input fiw_byte_t d);
        wr(8'h10, 8'h00);
        wr(a, d);
    endtask : clr
endmodule : fiw_host

`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "fiw_map.svh"

module tb_top;
    import fiw_pkg::*;
    logic clk;
    logic rst_n;
    logic clk_en;
    logic [7:0] reg_addr;
    fiw_byte_t reg_wdata;
    logic reg_wr;
    logic reg_rd;
    fiw_byte_t reg_rdata;
    logic [55:0] fault_det_in;
    logic fault_alert_n;
    fiw_mv_t ccl_mv;
    fiw_mv_t acl_mv;
    fiw_byte_t exp_q[$];
    fiw_byte_t thr;
    fiw_byte_t sreg;
    fiw_byte_t bit_v;
    logic rd_pend;
    logic [31:0] lfsr_q;
    int fails;
    int total_checks;
    int n;

    fiw_regs u_dut (
        .clk(clk), .rst_n(rst_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fault_det_in(fault_det_in), .fault_alert_n(fault_alert_n),
        .constant_current_loop_mv(ccl_mv),
        .average_current_limit_mv(acl_mv)
    );

    fiw_host u_host (
        .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic rd(input logic [7:0] a, input fiw_byte_t e);
        exp_q.push_back(e);
        u_host.rd(a);
    endtask : rd

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    // ************************************************
    // Read data monitor: one result per read strobe
    // ************************************************
    always @(posedge clk) begin
        if (rd_pend) begin
            check({4'h0, reg_rdata}, {4'h0, exp_q.pop_front()});
        end
        rd_pend <= reg_rd;
    end

    initial begin
        #100000;
        fails++;
        finish_test();
    end

    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        fault_det_in = '0;
        rd_pend = 1'b0;
        fails = 0;
        total_checks = 0;
        lfsr_q = 32'ha58c_d026;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        check(ccl_mv, 12'h0960);
        check(acl_mv, 12'h0A8C);
        check({11'h000, fault_alert_n}, 12'h001);
        rd(`FIW_ADDR_WRITE_GUARD, 8'h00);
        rd(`FIW_ADDR_THRESHOLDS, 8'h00);
        rd(`FIW_ADDR_FAULT_INDEX, 8'h00);
        // Both fields walk all codes in opposite order
        for (n = 0; n < 8; n++) begin
            lfsr_q = lfsr_next(lfsr_q);
            thr = {lfsr_q[1:0], 3'(7 - n), 3'(n)};
            u_host.wr(`FIW_ADDR_THRESHOLDS, thr);
            repeat (2) @(posedge clk);
            check(ccl_mv, 12'h0960 - 12'(n) * 12'h0064);
            check(acl_mv, 12'h0A8C - 12'(7 - n) * 12'h0064);
            rd(`FIW_ADDR_THRESHOLDS, thr & 8'h3F);
        end
        // Enable held low: the write must not land
        @(posedge clk);
        clk_en <= 1'b0;
        u_host.wr(`FIW_ADDR_THRESHOLDS, 8'h00);
        clk_en <= 1'b1;
        repeat (2) @(posedge clk);
        check(ccl_mv, 12'h0960 - 12'h0064 * 12'h0007);
        rd(`FIW_ADDR_THRESHOLDS, thr & 8'h3F);
        u_host.wr(`FIW_ADDR_WRITE_GUARD, 8'hFF);
        rd(`FIW_ADDR_WRITE_GUARD, 8'h80);
        u_host.wr(`FIW_ADDR_THRESHOLDS, 8'h00);
        repeat (3) @(posedge clk);
        rd(`FIW_ADDR_THRESHOLDS, thr & 8'h3F);
        check(ccl_mv, 12'h0960 - 12'h0064 * 12'h0007);
        for (n = 0; n < 7; n++) begin
            lfsr_q = lfsr_next(lfsr_q);
            bit_v = 8'h01 << lfsr_q[2:0];
            sreg = 8'(`FIW_ADDR_FAULT_FIRST + n);
            @(posedge clk);
            fault_det_in <= 56'(bit_v) << (8 * n);
            repeat (2) @(posedge clk);
            fault_det_in <= '0;
            repeat (4) @(posedge clk);
            check({11'h000, fault_alert_n}, 12'h000);
            rd(`FIW_ADDR_FAULT_INDEX, 8'h80 | (8'h01 << n));
            rd(sreg, bit_v);
            // Clearing with the guard closed must be ignored
            u_host.wr(sreg, bit_v);
            u_host.wr(`FIW_ADDR_CLEAR_ALL, 8'h00);
            rd(sreg, bit_v);
            if (n % 2 == 1) begin
                u_host.clr(`FIW_ADDR_CLEAR_ALL, 8'h00);
            end else begin
                u_host.clr(sreg, bit_v);
            end
            repeat (4) @(posedge clk);
            check({11'h000, fault_alert_n}, 12'h001);
            rd(`FIW_ADDR_FAULT_INDEX, 8'h00);
            rd(sreg, 8'h00);
            u_host.wr(`FIW_ADDR_WRITE_GUARD, 8'h80);
        end
        repeat (4) @(posedge clk);
        finish_test();
    end
endmodule : tb_top

`default_nettype wire
